/* hdl/ien_ctrl.sv */
// interrupt controller: sampling, priority, entry, return, wake, edges
`timescale 1ns/1ps
module ien_ctrl
  import ien_pkg::*;
#(
  parameter int NSRC = 8,
  parameter logic [23:0] VEC_BASE = 24'h000020
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [IEN_NUM_EXT-1:0] ext_pin,
  input wire logic [NSRC-1:0] periph_event,
  input wire logic core_instr_done,
  input wire logic core_asleep,
  input wire logic return_from_interrupt_instruction_req,
  input wire logic [23:0] core_pc,
  input wire logic [7:0] core_status_low_byte,
  input wire logic [23:0] isr_addr,
  input wire ien_frame_t pop_frame,
  output logic irq,
  output logic wake,
  output logic adc_trig,
  output logic stack_push,
  output ien_frame_t push_frame,
  output logic stack_pop,
  output logic pc_load,
  output logic [23:0] pc_value,
  output logic [2:0] cpu_priority_field,
  output logic priority_extension_bit
);
  ////////////////////////////////////////////////////////////////////////
  // state
  ien_state_t state_ff;
  ien_state_t nxt_state;
  logic nest_dis_ff;
  logic [IEN_NUM_EXT-1:0] pol_ff;
  logic [IEN_NUM_EXT-1:0] pin_prev_ff;
  logic prev_ok_ff;
  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] enable_ff;
  logic [NSRC*IEN_PRI_W-1:0] prio_ff;
  logic [2:0] cpu_pri_ff;
  logic ext_ff;
  logic [3:0] act_id_ff;
  logic [2:0] act_pri_ff;
  ien_frame_t buf_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic wake_ff;
  logic adc_trig_ff;
  logic stack_push_ff;
  ien_frame_t push_frame_ff;
  logic stack_pop_ff;
  logic pc_load_ff;
  logic [23:0] pc_value_ff;
  ien_apb_req_t req;
  logic [IEN_NUM_EXT-1:0] ext_edge;
  logic [NSRC-1:0] flag_set;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] wake_vec;
  logic [NSRC-1:0] above;
  logic [2:0] best_pri;
  logic [3:0] best_id;
  logic go;
  logic wr_en;
  logic wr_flag;
  logic wr_status;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign wr_en = req.psel && req.penable && req.pwrite && pready_ff;
  assign wr_flag = wr_en && (req.paddr == IEN_ADDR_FLAG);
  assign wr_status = wr_en && (req.paddr == IEN_ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // external edge detectors, flags and arbitration
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : gen_src
      if (g < IEN_NUM_EXT)
      begin : gen_ext
        // polarity one selects falling edge; no edge before a first sample
        assign ext_edge[g] = prev_ok_ff && (pol_ff[g] ?
          (pin_prev_ff[g] && !ext_pin[g]) :
          (!pin_prev_ff[g] && ext_pin[g]));
        assign flag_set[g] = ext_edge[g] || periph_event[g];
      end
      else
      begin : gen_per
        assign flag_set[g] = periph_event[g];
      end
      assign pend[g] = flag_ff[g] && enable_ff[g];
      assign wake_vec[g] = pend[g] &&
        (prio_ff[g*IEN_PRI_W +: IEN_PRI_W] != IEN_LEVEL_OFF);
      // per-source check against the level, free of the arbitration
      assign above[g] = pend[g] &&
        ({1'b0, prio_ff[g*IEN_PRI_W +: IEN_PRI_W]} >
         {ext_ff, cpu_pri_ff});
    end
  endgenerate

  always_comb
  begin
    best_pri = IEN_LEVEL_OFF;
    best_id = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      // scanning downward with >= leaves the lowest vector on a tie
      if (pend[i] && (prio_ff[i*IEN_PRI_W +: IEN_PRI_W] >= best_pri) &&
          (prio_ff[i*IEN_PRI_W +: IEN_PRI_W] != IEN_LEVEL_OFF))
      begin
        best_pri = prio_ff[i*IEN_PRI_W +: IEN_PRI_W];
        best_id = 4'(i);
      end
    end
  end

  // strict compare against the four-bit effective level
  assign go = ({1'b0, best_pri} > {ext_ff, cpu_pri_ff}) &&
              (best_pri != IEN_LEVEL_OFF);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev_ff <= '0;
      prev_ok_ff <= 1'b0;
    end
    else
    begin
      pin_prev_ff <= ext_pin;
      prev_ok_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_ff <= '0;
    else if (wr_flag)
      flag_ff <= (flag_ff & ~req.pwdata[NSRC-1:0]) | flag_set;
    else
      flag_ff <= flag_ff | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      adc_trig_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= go;
      wake_ff <= core_asleep && (|wake_vec);
      adc_trig_ff <= ext_edge[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // entry and return sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      IEN_ST_IDLE:
        if (go)
          nxt_state = IEN_ST_E2;
        else if (return_from_interrupt_instruction_req)
          nxt_state = IEN_ST_R1;
      IEN_ST_E2:
        if (core_instr_done)
          nxt_state = IEN_ST_E3;
      IEN_ST_E3:
        nxt_state = IEN_ST_E4;
      IEN_ST_E4:
        nxt_state = IEN_ST_IDLE;
      IEN_ST_R1:
        nxt_state = IEN_ST_R2;
      IEN_ST_R2:
        nxt_state = IEN_ST_R3;
      IEN_ST_R3:
        nxt_state = IEN_ST_IDLE;
      default:
        nxt_state = IEN_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= IEN_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_id_ff <= 4'h0;
      act_pri_ff <= IEN_LEVEL_OFF;
    end
    else if (state_ff == IEN_ST_IDLE && go)
    begin
      act_id_ff <= best_id;
      act_pri_ff <= best_pri;
    end
  end

  // second entry cycle: temporary buffer, vector address load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buf_ff <= '0;
    else if (state_ff == IEN_ST_E2)
      buf_ff <= '{core_pc, core_status_low_byte, ext_ff};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_push_ff <= 1'b0;
      push_frame_ff <= '0;
    end
    else
    begin
      stack_push_ff <= (state_ff == IEN_ST_E3);
      if (state_ff == IEN_ST_E3)
        push_frame_ff <= buf_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stack_pop_ff <= 1'b0;
    else
      stack_pop_ff <= (nxt_state == IEN_ST_R1) ||
                      (nxt_state == IEN_ST_R2);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= '0;
    end
    else
    begin
      pc_load_ff <= 1'b0;
      case (state_ff)
        IEN_ST_E2:
          if (core_instr_done)
          begin
            pc_load_ff <= 1'b1;
            pc_value_ff <= VEC_BASE + 24'({act_id_ff, 1'b0});
          end
        IEN_ST_E3:
        begin
          pc_load_ff <= 1'b1;
          pc_value_ff <= isr_addr;
        end
        IEN_ST_R1:
          pc_value_ff[23:16] <= pop_frame.pc[23:16];
        IEN_ST_R2:
        begin
          pc_load_ff <= 1'b1;
          pc_value_ff[15:0] <= pop_frame.pc[15:0];
        end
        default:
          pc_load_ff <= 1'b0;
      endcase
    end
  end

  // cpu level: entry write, return restore, software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_pri_ff <= IEN_CPU_PRI_RST;
      ext_ff <= 1'b0;
    end
    else if (state_ff == IEN_ST_E4)
      cpu_pri_ff <= nest_dis_ff ? IEN_LEVEL_MAX : act_pri_ff;
    else if (state_ff == IEN_ST_R1)
    begin
      cpu_pri_ff <= pop_frame.status_low_byte[7:5];
      ext_ff <= pop_frame.priority_extension_bit;
    end
    else if (wr_status)
    begin
      if (!nest_dis_ff)
        cpu_pri_ff <= req.pwdata[IEN_CPU_PRI_LSB +: 3];
      if (!req.pwdata[IEN_EXT_BIT])
        ext_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nest_dis_ff <= 1'b0;
      pol_ff <= IEN_POL_RST;
      enable_ff <= '0;
      prio_ff <= '0;
    end
    else if (wr_en)
    begin
      case (req.paddr)
        IEN_ADDR_CTRL:
        begin
          nest_dis_ff <= req.pwdata[IEN_NEST_DIS_BIT];
          pol_ff <= req.pwdata[IEN_POL_LSB +: IEN_NUM_EXT];
        end
        IEN_ADDR_ENABLE:
          enable_ff <= req.pwdata[NSRC-1:0];
        IEN_ADDR_PRIO:
          prio_ff <= req.pwdata[NSRC*IEN_PRI_W-1:0];
        default:
          nest_dis_ff <= nest_dis_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= req.psel && !req.penable;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      if (req.psel && !req.penable)
      begin
        case (req.paddr)
          IEN_ADDR_CTRL:
          begin
            prdata_ff[IEN_NEST_DIS_BIT] <= nest_dis_ff;
            prdata_ff[IEN_POL_LSB +: IEN_NUM_EXT] <= pol_ff;
          end
          IEN_ADDR_FLAG:
            prdata_ff[NSRC-1:0] <= flag_ff;
          IEN_ADDR_ENABLE:
            prdata_ff[NSRC-1:0] <= enable_ff;
          IEN_ADDR_PRIO:
            prdata_ff[NSRC*IEN_PRI_W-1:0] <= prio_ff;
          IEN_ADDR_STATUS:
          begin
            prdata_ff[IEN_CPU_PRI_LSB +: 3] <= cpu_pri_ff;
            prdata_ff[IEN_EXT_BIT] <= ext_ff;
            prdata_ff[IEN_STATE_LSB +: 3] <= state_ff;
            prdata_ff[IEN_ACT_ID_LSB +: 4] <= act_id_ff;
          end
          default:
            pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign wake = wake_ff;
  assign adc_trig = adc_trig_ff;
  assign stack_push = stack_push_ff;
  assign push_frame = push_frame_ff;
  assign stack_pop = stack_pop_ff;
  assign pc_load = pc_load_ff;
  assign pc_value = pc_value_ff;
  assign cpu_priority_field = cpu_pri_ff;
  assign priority_extension_bit = ext_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ent_tail;
    state_ff == IEN_ST_E3 && pc_load_ff ##1
    state_ff == IEN_ST_E4 && stack_push_ff && pc_load_ff ##1
    state_ff == IEN_ST_IDLE;
  endsequence

  sequence s_ret;
    state_ff == IEN_ST_R1 && stack_pop_ff ##1
    state_ff == IEN_ST_R2 && stack_pop_ff ##1
    state_ff == IEN_ST_R3 && pc_load_ff && !stack_pop_ff;
  endsequence

  a_entry_four_cycles: assert property (
    (state_ff == IEN_ST_IDLE && go) ##1 core_instr_done |=> s_ent_tail)
    else $error("entry did not complete in four cycles");

  a_entry_waits_done: assert property (
    (state_ff == IEN_ST_E2 && !core_instr_done) |=> state_ff == IEN_ST_E2)
    else $error("entry advanced before instruction completed");

  a_push_buffer: assert property (
    (state_ff == IEN_ST_E2 && core_instr_done) ##1 1'b1
    |=> push_frame_ff.pc == $past(core_pc, 2))
    else $error("stacked program counter differs from buffered one");

  a_level_after_entry: assert property (
    (state_ff == IEN_ST_E4 && !nest_dis_ff) |=> cpu_pri_ff == act_pri_ff)
    else $error("cpu level not set to serviced priority");

  a_nest_force_seven: assert property (
    (state_ff == IEN_ST_E4 && nest_dis_ff) |=> cpu_pri_ff == 3'h7)
    else $error("nesting disabled but level not forced to seven");

  a_level_readonly: assert property (
    (wr_status && nest_dis_ff && state_ff == IEN_ST_IDLE)
    |=> $stable(cpu_pri_ff))
    else $error("cpu level written while nesting disabled");

  a_return_three: assert property (
    (state_ff == IEN_ST_IDLE && !go && return_from_interrupt_instruction_req) |=> s_ret)
    else $error("return did not run its three cycles");

  a_return_restore: assert property (
    state_ff == IEN_ST_R1 |=> cpu_pri_ff ==
      $past(pop_frame.status_low_byte[7:5]) ##2 pc_value_ff[15:0] ==
      $past(pop_frame.pc[15:0], 2))
    else $error("return did not restore level and program counter");

  a_irq_needs_level: assert property (
    irq_ff == $past(|above))
    else $error("interrupt presented at or below cpu level");

  a_wake_cause: assert property (
    wake_ff |-> $past(core_asleep && (|wake_vec)))
    else $error("wake without enabled nonzero priority request");

  a_ext_edge_flag: assert property (
    ext_edge[0] |=> flag_ff[0] && adc_trig_ff)
    else $error("edge on source zero lost or trigger missing");
endmodule : ien_ctrl

/* hdl/ien_pkg.sv */
// shared constants and types of the interrupt entry and nesting controller
package ien_pkg;
  // register byte offsets
  localparam logic [7:0] IEN_ADDR_CTRL = 8'h00;
  localparam logic [7:0] IEN_ADDR_FLAG = 8'h04;
  localparam logic [7:0] IEN_ADDR_ENABLE = 8'h08;
  localparam logic [7:0] IEN_ADDR_PRIO = 8'h0c;
  localparam logic [7:0] IEN_ADDR_STATUS = 8'h10;
  // control register fields
  localparam int IEN_NEST_DIS_BIT = 15;
  localparam int IEN_POL_LSB = 0;
  // status register fields
  localparam int IEN_CPU_PRI_LSB = 5;
  localparam int IEN_EXT_BIT = 8;
  localparam int IEN_STATE_LSB = 9;
  localparam int IEN_ACT_ID_LSB = 16;
  // counts and levels
  localparam int IEN_NUM_EXT = 5;
  localparam int IEN_PRI_W = 3;
  localparam logic [2:0] IEN_LEVEL_MAX = 3'h7;
  localparam logic [2:0] IEN_LEVEL_OFF = 3'h0;
  localparam logic [2:0] IEN_CPU_PRI_RST = 3'h0;
  localparam logic [4:0] IEN_POL_RST = 5'h00;
  localparam int IEN_ENTRY_CYCLES = 4;
  localparam int IEN_RET_CYCLES = 3;

  // entry and return sequencer states
  typedef enum logic [2:0] {
    IEN_ST_IDLE = 3'b000,
    IEN_ST_E2 = 3'b001,
    IEN_ST_E3 = 3'b010,
    IEN_ST_E4 = 3'b011,
    IEN_ST_R1 = 3'b100,
    IEN_ST_R2 = 3'b101,
    IEN_ST_R3 = 3'b110
  } ien_state_t;

  // one stack frame: program counter, status low byte, extension bit
  typedef struct packed {
    logic [23:0] pc;
    logic [7:0] status_low_byte;
    logic priority_extension_bit;
  } ien_frame_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ien_apb_req_t;
endpackage : ien_pkg

/* tb/ien_core_model.sv */
// processor core model: program counter, status byte and software stack
`timescale 1ns/1ps
module ien_core_model
  import ien_pkg::*;
#(
  parameter logic [23:0] START_PC = 24'h000400
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pc_load,
  input wire logic [23:0] pc_value,
  input wire logic stack_push,
  input wire ien_frame_t push_frame,
  input wire logic stack_pop,
  input wire logic [2:0] cpu_priority_field,
  output logic core_instr_done,
  output logic [23:0] core_pc,
  output logic [7:0] core_status_low_byte,
  output logic [23:0] isr_addr,
  output ien_frame_t pop_frame
);
  ien_frame_t stack_ff [8];
  logic [2:0] sp_ff;
  logic half_ff;
  logic [23:0] pc_ff;
  assign core_instr_done = 1'b1;
  assign core_pc = pc_ff;
  assign core_status_low_byte = {cpu_priority_field, 5'h0b};
  // routine address comes from the vector slot; junk outside a fetch
  assign isr_addr = pc_load ? pc_value + 24'h000100 : ~pc_ff;
  // an empty stack shows an inverted pattern, not a stale frame
  assign pop_frame = (sp_ff != 3'h0) ? stack_ff[sp_ff - 3'h1] : ~stack_ff[0];
  ////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_ff <= START_PC;
      sp_ff <= 3'h0;
      half_ff <= 1'b0;
    end
    else
    begin
      if (pc_load)
        pc_ff <= pc_value;
      if (stack_push)
      begin
        stack_ff[sp_ff] <= push_frame;
        sp_ff <= sp_ff + 3'h1;
      end
      if (stack_pop)
        half_ff <= !half_ff;
      // the frame leaves after its second pop cycle
      if (stack_pop && half_ff)
        sp_ff <= sp_ff - 3'h1;
    end
  end
endmodule : ien_core_model

/* tb/test_interrupt_entry_nesting_wakeup.sv */
// self-checking bench of the interrupt controller with a core model
`timescale 1ns/1ps
module test_interrupt_entry_nesting_wakeup
  import ien_pkg::*;
;
  localparam logic [23:0] VB = 24'h000020;
  localparam logic [23:0] START_PC = 24'h000400;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] ext_pin = 5'h00;
  logic [7:0] periph_event = 8'h00;
  logic core_asleep = 1'b0;
  logic return_from_interrupt_instruction_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, core_instr_done, irq, wake, adc_trig;
  logic stack_push, stack_pop, pc_load, priority_extension_bit;
  logic [23:0] core_pc, isr_addr, pc_value;
  logic [7:0] core_status_low_byte;
  logic [2:0] cpu_priority_field;
  ien_frame_t pop_frame, push_frame;
  int mismatches = 0;
  int num_checks = 0;
  int trig_cnt = 0;
  int t;

  ien_ctrl #(.NSRC(8), .VEC_BASE(VB)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
    .periph_event(periph_event), .core_instr_done(core_instr_done),
    .core_asleep(core_asleep), .return_from_interrupt_instruction_req(return_from_interrupt_instruction_req),
    .core_pc(core_pc), .core_status_low_byte(core_status_low_byte),
    .isr_addr(isr_addr), .pop_frame(pop_frame), .irq(irq), .wake(wake),
    .adc_trig(adc_trig), .stack_push(stack_push),
    .push_frame(push_frame), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_value(pc_value), .cpu_priority_field(cpu_priority_field),
    .priority_extension_bit(priority_extension_bit));
  ien_core_model #(.START_PC(START_PC)) core (
    .pclk(pclk), .presetn(presetn), .pc_load(pc_load),
    .pc_value(pc_value), .stack_push(stack_push),
    .push_frame(push_frame), .stack_pop(stack_pop),
    .cpu_priority_field(cpu_priority_field),
    .core_instr_done(core_instr_done), .core_pc(core_pc),
    .core_status_low_byte(core_status_low_byte), .isr_addr(isr_addr),
    .pop_frame(pop_frame));

  always #50 pclk = ~pclk;
  always @(posedge pclk)
    if (adc_trig === 1'b1)
      trig_cnt++;
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bound(input int n);
    if (n >= 50)
    begin
      mismatches++;
      stop_test();
    end
  endtask : bound
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    bound(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] mask,
    input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    cmp(rd & mask, exp);
    cmp(32'(er), 32'(experr));
  endtask : chk
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    periph_event <= m;
    @(posedge pclk);
    periph_event <= 8'h00;
    repeat (4) @(posedge pclk);
  endtask : pulse
  // one entry: vector load, routine load with push, new level
  task automatic enter(input logic [7:0] m, input int id,
    input logic [2:0] lvl, input logic [2:0] old, input logic [23:0] rpc);
    logic [23:0] vec;
    int n;
    vec = VB + 24'(2 * id);
    @(posedge pclk);
    periph_event <= m;
    @(posedge pclk);
    periph_event <= 8'h00;
    n = 1;
    while (pc_load !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    bound(n);
    cmp(32'(n), 32'h4);
    cmp(32'(pc_value), 32'(vec));
    @(posedge pclk);
    cmp(32'(pc_value), 32'(vec + 24'h000100));
    cmp(32'({pc_load, stack_push}), 32'h3);
    cmp({push_frame.pc, push_frame.status_low_byte}, {rpc, old, 5'h0b});
    cmp(32'({irq, push_frame.priority_extension_bit}), 32'h2);
    repeat (2) @(posedge pclk);
    cmp(32'(cpu_priority_field), 32'(lvl));
  endtask : enter
  task automatic leave(input logic [23:0] pc, input logic [2:0] lvl);
    int n;
    @(posedge pclk);
    return_from_interrupt_instruction_req <= 1'b1;
    n = 0;
    while (stack_pop !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    bound(n);
    return_from_interrupt_instruction_req <= 1'b0;
    @(posedge pclk);
    cmp(32'(stack_pop), 32'h1);
    @(posedge pclk);
    cmp(32'({pc_load, pc_value}), {7'h0, 1'b1, pc});
    repeat (2) @(posedge pclk);
    cmp(32'(cpu_priority_field), 32'(lvl));
  endtask : leave
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(32'({irq, wake, stack_pop, pc_load, cpu_priority_field,
      priority_extension_bit}), 32'h0);
    chk(IEN_ADDR_CTRL, 32'hffffffff, 32'h0, 1'b0);
    chk(IEN_ADDR_STATUS, 32'h1e0, 32'h0, 1'b0);
    chk(8'h14, 32'hffffffff, 32'h0, 1'b1);
    wr(IEN_ADDR_PRIO, 32'h000280d9);
    wr(IEN_ADDR_ENABLE, 32'h67);
    enter(8'h06, 1, 3'h3, 3'h0, START_PC);
    chk(IEN_ADDR_FLAG, 32'hff, 32'h06, 1'b0);
    wr(IEN_ADDR_FLAG, 32'h02);
    repeat (4) @(posedge pclk);
    cmp(32'(irq), 32'h0);
    enter(8'h20, 5, 3'h5, 3'h3, VB + 24'h000102);
    wr(IEN_ADDR_FLAG, 32'h20);
    leave(VB + 24'h000102, 3'h3);
    wr(IEN_ADDR_FLAG, 32'h04);
    leave(START_PC, 3'h0);
    wr(IEN_ADDR_CTRL, 32'h8000);
    enter(8'h01, 0, 3'h7, 3'h0, START_PC);
    wr(IEN_ADDR_STATUS, 32'h0);
    chk(IEN_ADDR_STATUS, 32'he0, 32'he0, 1'b0);
    pulse(8'h20);
    cmp(32'(irq), 32'h0);
    wr(IEN_ADDR_FLAG, 32'h21);
    leave(START_PC, 3'h0);
    wr(IEN_ADDR_CTRL, 32'h0);
    core_asleep <= 1'b1;
    pulse(8'h40);
    cmp(32'({wake, irq}), 32'h0);
    wr(IEN_ADDR_FLAG, 32'h40);
    wr(IEN_ADDR_STATUS, 32'h80);
    chk(IEN_ADDR_STATUS, 32'he0, 32'h80, 1'b0);
    pulse(8'h01);
    cmp(32'({wake, irq}), 32'h2);
    wr(IEN_ADDR_FLAG, 32'h01);
    repeat (3) @(posedge pclk);
    cmp(32'(wake), 32'h0);
    core_asleep <= 1'b0;
    wr(IEN_ADDR_STATUS, 32'h0);
    wr(IEN_ADDR_ENABLE, 32'h0);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < IEN_NUM_EXT; i++)
      begin
        wr(IEN_ADDR_CTRL, (p != 0) ? 32'h1f : 32'h0);
        ext_pin <= (p != 0) ? 5'h1f : 5'h00;
        repeat (3) @(posedge pclk);
        wr(IEN_ADDR_FLAG, 32'hff);
        t = trig_cnt;
        ext_pin[i] <= (p == 0);
        repeat (4) @(posedge pclk);
        cmp(32'(trig_cnt - t), 32'(i == 0));
        chk(IEN_ADDR_FLAG, 32'hff, 32'h1 << i, 1'b0);
        wr(IEN_ADDR_FLAG, 32'hff);
        ext_pin[i] <= (p != 0);
        repeat (4) @(posedge pclk);
        chk(IEN_ADDR_FLAG, 32'hff, 32'h0, 1'b0);
      end
    // reset again with all pins high: no false edge may follow it
    t = trig_cnt;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp(32'(trig_cnt - t), 32'h0);
    cmp(32'({irq, wake, stack_pop, pc_load, cpu_priority_field}), 32'h0);
    chk(IEN_ADDR_FLAG, 32'hff, 32'h0, 1'b0);
    chk(IEN_ADDR_CTRL, 32'hffffffff, 32'h0, 1'b0);
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule : test_interrupt_entry_nesting_wakeup
